// ==== pkg/flash_cmd_pkg.sv ====
// Purpose: shared constants and carriers for the flash power-down / id / suspend interpreter
// Assumes: one 125 MHz system clock; serial pins sampled by that clock
// Notes:   opcodes, frame lengths and resume timing live here; the delay figures are parameters of the interpreter
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } pin_in_s;

  typedef enum logic [1:0] {
    ENG_PROGRAM,
    ENG_ERASE,
    ENG_STATUS_WRITE,
    ENG_OTHER
  } eng_kind_e;

  typedef struct packed {
    logic      busy;
    eng_kind_e kind;
  } eng_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } fwd_s;

  typedef struct packed {
    logic suspend_req;
    logic resume_req;
    logic abort_req;
  } eng_ctl_s;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
  localparam logic [7:0] OP_RELEASE_ID   = 8'hAB;
  localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_IDENT_READ   = 8'h9F;
  localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;
  localparam logic [7:0] OP_SUSPEND      = 8'h75;
  localparam logic [7:0] OP_RESUME       = 8'h7A;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;
  localparam logic [7:0] OP_WRSR_1       = 8'h01;
  localparam logic [7:0] OP_WRSR_2       = 8'h31;
  localparam logic [7:0] OP_WRSR_3       = 8'h11;
  localparam logic [7:0] OP_SEC_ERASE    = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM  = 8'h42;
  localparam logic [7:0] OP_ERASE_4K     = 8'h20;
  localparam logic [7:0] OP_ERASE_32K    = 8'h52;
  localparam logic [7:0] OP_ERASE_64K    = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP_1 = 8'hC7;
  localparam logic [7:0] OP_ERASE_CHIP_2 = 8'h60;
  localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG    = 8'h32;

  // ----------------------------------------------------------------
  // frame lengths in bits: header lengths include the opcode, output lengths are data only
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_BITS        = 6'h08;
  localparam logic [5:0] HDR_RELEASE_ID = 6'h20;
  localparam logic [5:0] HDR_MAKER_DEV  = 6'h20;
  localparam logic [5:0] HDR_IDENT      = 6'h08;
  localparam logic [5:0] HDR_UNIQUE     = 6'h28;
  localparam logic [5:0] CNT_MAX        = 6'h3F;
  localparam logic [7:0] LEN_DEV_ID     = 8'h08;
  localparam logic [7:0] LEN_MAKER_DEV  = 8'h10;
  localparam logic [7:0] LEN_IDENT      = 8'h18;
  localparam logic [7:0] LEN_UNIQUE     = 8'h80;

  // ----------------------------------------------------------------
  // suspend flag positions, timing
  // ----------------------------------------------------------------
  localparam int SUSP_PROG   = 0;
  localparam int SUSP_ERASE  = 1;
  localparam int CLK_MHZ     = 125;
  localparam int RESUME_NS   = 200;
  localparam int RESUME_CYC  = (RESUME_NS * CLK_MHZ) / 1000;
  localparam int BUSY_SET_CYC = 1;

endpackage

// ==== verilog/pin_sync.sv ====
// Purpose: two-flop synchroniser bank for pins from outside the clock domain
// Assumes: rst_n is already synchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1)
  begin : g_check
    $error("pin_sync width must be at least one");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_r[i] <= RST_VAL[i];
        q[i]      <= RST_VAL[i];
      end
      else
      begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end

endmodule

// ==== verilog/flash_powerdown_id_suspend.sv ====
// Purpose: serial flash interpreter for power-down, id reads, suspend/resume, soft reset
// Assumes: engine status comes from logic on the same clock; sclk far slower than clock
// Notes:   other opcodes are forwarded once decoded unless refused by mode or inside a release/reset hold
`timescale 1ns/100ps

module flash_powerdown_id_suspend
  import flash_cmd_pkg::*;
#(
  parameter int             T_DP_NS   = 3000,
  parameter int             T_RES1_NS = 3000,
  parameter int             T_RES2_NS = 8000,
  parameter int             T_RST_NS  = 30000,
  // identity values below are arbitrary
  parameter logic [7:0]     MAKER_ID  = 8'hA5,
  parameter logic [7:0]     DEV_ID    = 8'h5A,
  parameter logic [7:0]     MEM_TYPE  = 8'h3C,
  parameter logic [7:0]     CAPACITY  = 8'h16,
  parameter logic [127:0]   UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  flash_cmd_pkg::pin_in_s  pins,
  input  flash_cmd_pkg::eng_s     eng,
  output logic              so,
  output logic              so_oe,
  output flash_cmd_pkg::fwd_s     fwd,
  output flash_cmd_pkg::eng_ctl_s eng_ctl,
  output logic              busy_flag,
  output logic [1:0]        suspend_flags,
  output logic              power_down,
  output logic              standby
);
  import flash_cmd_pkg::*;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [23:0] DP_CYC   = 24'((T_DP_NS   * CLK_MHZ + 999) / 1000);
  localparam logic [23:0] RES1_CYC = 24'((T_RES1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [23:0] RES2_CYC = 24'((T_RES2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [23:0] RST_CYC  = 24'((T_RST_NS  * CLK_MHZ + 999) / 1000);

  if (T_DP_NS < 1 || T_RES1_NS < 1 || T_RES2_NS < 1 || T_RST_NS < 1 ||
      RST_CYC == 24'h0 || RESUME_CYC < BUSY_SET_CYC)
  begin : g_check
    $error("timing parameters out of range");
  end

  typedef enum logic [2:0] {PH_IDLE, PH_OP, PH_HDR, PH_OUT, PH_SKIP} phase_e;

  // ----------------------------------------------------------------
  // reset release and pin sampling
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;
  pin_in_s    pin_s;
  logic       cs_q_r;
  logic       sclk_q_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  pin_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h4)
  ) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pins),
    .q     (pin_s)
  );

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q_r   <= 1'b1;
      sclk_q_r <= 1'b0;
    end
    else
    begin
      cs_q_r   <= pin_s.cs_n;
      sclk_q_r <= pin_s.sclk;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = pin_s.sclk & ~sclk_q_r;
  assign sclk_fall = ~pin_s.sclk & sclk_q_r;
  assign cs_fall   = ~pin_s.cs_n & cs_q_r;
  assign cs_rise   = pin_s.cs_n & ~cs_q_r;

  // ----------------------------------------------------------------
  // mode state declarations
  // ----------------------------------------------------------------
  logic        pd_r, pd_nxt;
  logic        pd_pend_r, pd_pend_nxt;
  logic [23:0] pd_cnt_r, pd_cnt_nxt;
  logic [23:0] hold_r, hold_nxt;
  logic [1:0]  susp_r, susp_nxt;
  logic        busy_r, busy_nxt;
  logic        stby_r, stby_nxt;
  logic        rst_en_r, rst_en_nxt;
  eng_ctl_s    ctl_r, ctl_nxt;
  logic        locked;
  assign locked = (hold_r != 24'h0);

  // refusals by mode for opcodes handed to neighbouring logic
  function automatic logic refused(input logic [7:0] op, input logic pd,
                                   input logic [1:0] susp);
    logic wr_erase;
    logic prog;
    wr_erase = (op == OP_WRSR_1) || (op == OP_WRSR_2) || (op == OP_WRSR_3) ||
               (op == OP_SEC_ERASE) || (op == OP_ERASE_4K) || (op == OP_ERASE_32K) ||
               (op == OP_ERASE_64K) || (op == OP_ERASE_CHIP_1) || (op == OP_ERASE_CHIP_2);
    prog     = (op == OP_SEC_PROGRAM) || (op == OP_PAGE_PROG) || (op == OP_QUAD_PROG);
    refused  = pd
             | (susp[SUSP_PROG] & (wr_erase | prog))
             | (susp[SUSP_ERASE] & wr_erase);
  endfunction

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  phase_e       phase_r, phase_nxt;
  logic [5:0]   cnt_r, cnt_nxt;
  logic [5:0]   hdr_r, hdr_nxt;
  logic [7:0]   op_r, op_nxt;
  logic [7:0]   dlen_r, dlen_nxt;
  logic [6:0]   idx_r, idx_nxt;
  logic [127:0] data_r, data_nxt;
  logic         so_r, so_nxt;
  logic         so_oe_r, so_oe_nxt;
  fwd_s         fwd_r, fwd_nxt;

  always_comb
  begin
    logic [7:0] op_in;
    logic [6:0] sel;
    op_in     = {op_r[6:0], pin_s.si};
    sel       = 7'(dlen_r - 8'h01 - {1'b0, idx_r});
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    hdr_nxt   = hdr_r;
    op_nxt    = op_r;
    dlen_nxt  = dlen_r;
    idx_nxt   = idx_r;
    data_nxt  = data_r;
    so_nxt    = so_r;
    so_oe_nxt = (phase_r == PH_OUT) & ~pin_s.cs_n;
    fwd_nxt   = '{valid: 1'b0, opcode: fwd_r.opcode};
    if (pin_s.cs_n)
    begin
      phase_nxt = PH_IDLE;
      so_oe_nxt = 1'b0;
    end
    else if (cs_fall)
    begin
      phase_nxt = PH_OP;
      cnt_nxt   = 6'h00;
      op_nxt    = 8'h00;
    end
    else if (sclk_rise && phase_r != PH_OUT)
    begin
      if (cnt_r != CNT_MAX)
        cnt_nxt = cnt_r + 6'h01;
      if (phase_r == PH_OP)
      begin
        op_nxt = op_in;
        if (cnt_r == OP_BITS - 6'h01)
        begin
          phase_nxt = PH_SKIP;
          idx_nxt   = 7'h00;
          if (!locked)
          begin
            unique case (op_in)
              OP_RELEASE_ID:
                if (!busy_r)
                begin
                  phase_nxt = PH_HDR;
                  hdr_nxt   = HDR_RELEASE_ID;
                  dlen_nxt  = LEN_DEV_ID;
                  data_nxt  = {120'h0, DEV_ID};
                end
              OP_MAKER_DEV_ID:
                if (!pd_r)
                begin
                  phase_nxt = PH_HDR;
                  hdr_nxt   = HDR_MAKER_DEV;
                  dlen_nxt  = LEN_MAKER_DEV;
                  data_nxt  = {112'h0, MAKER_ID, DEV_ID};
                end
              OP_IDENT_READ:
                if (!pd_r && !(eng.busy && eng.kind != ENG_STATUS_WRITE))
                begin
                  phase_nxt = PH_OUT;
                  hdr_nxt   = HDR_IDENT;
                  dlen_nxt  = LEN_IDENT;
                  data_nxt  = {104'h0, MAKER_ID, MEM_TYPE, CAPACITY};
                end
              OP_UNIQUE_ID:
                if (!pd_r)
                begin
                  phase_nxt = PH_HDR;
                  hdr_nxt   = HDR_UNIQUE;
                  dlen_nxt  = LEN_UNIQUE;
                  data_nxt  = UNIQUE_ID;
                end
              OP_POWER_DOWN, OP_SUSPEND, OP_RESUME, OP_RESET_ENABLE, OP_RESET:
                phase_nxt = PH_SKIP;
              default:
                fwd_nxt = '{valid: !refused(op_in, pd_r | pd_pend_r, susp_r),
                            opcode: op_in};
            endcase
          end
        end
      end
      else if (phase_r == PH_HDR && cnt_r + 6'h01 == hdr_r)
        phase_nxt = PH_OUT;
    end
    else if (sclk_fall && phase_r == PH_OUT)
    begin
      // id repeats until deselect
      so_nxt  = data_r[sel];
      idx_nxt = ({1'b0, idx_r} == dlen_r - 8'h01) ? 7'h00 : idx_r + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= PH_IDLE;
      cnt_r   <= 6'h00;
      hdr_r   <= 6'h00;
      op_r    <= 8'h00;
      dlen_r  <= 8'h08;
      idx_r   <= 7'h00;
      data_r  <= 128'h0;
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
      fwd_r   <= '0;
    end
    else
    begin
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
      hdr_r   <= hdr_nxt;
      op_r    <= op_nxt;
      dlen_r  <= dlen_nxt;
      idx_r   <= idx_nxt;
      data_r  <= data_nxt;
      so_r    <= so_nxt;
      so_oe_r <= so_oe_nxt;
      fwd_r   <= fwd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // modes, flags and engine control
  // ----------------------------------------------------------------
  logic exec8;
  logic rel_long;
  assign exec8    = cs_rise & (cnt_r == OP_BITS) & (phase_r != PH_OUT) & ~locked;
  assign rel_long = cs_rise & (op_r == OP_RELEASE_ID) & (phase_r == PH_OUT) & ~locked;

  always_comb
  begin
    logic in_pd;
    in_pd       = pd_r | pd_pend_r;
    pd_nxt      = pd_r;
    pd_pend_nxt = pd_pend_r;
    pd_cnt_nxt  = pd_cnt_r;
    hold_nxt    = locked ? hold_r - 24'h000001 : hold_r;
    susp_nxt    = susp_r;
    ctl_nxt     = '0;
    rst_en_nxt  = cs_rise ? 1'b0 : rst_en_r;
    busy_nxt    = eng.busy;
    if (pd_pend_r)
    begin
      if (pd_cnt_r <= 24'h000001)
      begin
        pd_pend_nxt = 1'b0;
        pd_nxt      = 1'b1;
      end
      else
        pd_cnt_nxt = pd_cnt_r - 24'h000001;
    end
    if (exec8 && op_r == OP_RESET_ENABLE)
      rst_en_nxt = 1'b1;
    if (exec8 && op_r == OP_RESET && rst_en_r)
    begin
      pd_nxt      = 1'b0;
      pd_pend_nxt = 1'b0;
      susp_nxt    = 2'h0;
      busy_nxt    = 1'b0;
      ctl_nxt.abort_req = 1'b1;
      hold_nxt    = RST_CYC;
    end
    else if ((exec8 || rel_long) && op_r == OP_RELEASE_ID && in_pd && !busy_r)
    begin
      pd_nxt      = 1'b0;
      pd_pend_nxt = 1'b0;
      hold_nxt    = exec8 ? RES1_CYC : RES2_CYC;
    end
    else if (exec8 && !in_pd)
    begin
      if (op_r == OP_POWER_DOWN && !busy_r && !eng.busy)
      begin
        pd_pend_nxt = 1'b1;
        pd_cnt_nxt  = DP_CYC;
      end
      else if (op_r == OP_SUSPEND && susp_r == 2'h0 && busy_r &&
               (eng.kind == ENG_PROGRAM || eng.kind == ENG_ERASE))
      begin
        susp_nxt[SUSP_PROG]  = (eng.kind == ENG_PROGRAM);
        susp_nxt[SUSP_ERASE] = (eng.kind == ENG_ERASE);
        ctl_nxt.suspend_req  = 1'b1;
      end
      else if (op_r == OP_RESUME && susp_r != 2'h0 && !busy_r)
      begin
        susp_nxt           = 2'h0;
        busy_nxt           = 1'b1;
        ctl_nxt.resume_req = 1'b1;
      end
    end
    // standby once deselected with nothing running and power-down neither entered nor pending
    stby_nxt = pin_s.cs_n & ~busy_nxt & ~pd_nxt & ~pd_pend_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_r      <= 1'b0;
      pd_pend_r <= 1'b0;
      pd_cnt_r  <= 24'h0;
      hold_r    <= 24'h0;
      susp_r    <= 2'h0;
      busy_r    <= 1'b0;
      stby_r    <= 1'b1;
      rst_en_r  <= 1'b0;
      ctl_r     <= '0;
    end
    else
    begin
      pd_r      <= pd_nxt;
      pd_pend_r <= pd_pend_nxt;
      pd_cnt_r  <= pd_cnt_nxt;
      hold_r    <= hold_nxt;
      susp_r    <= susp_nxt;
      busy_r    <= busy_nxt;
      stby_r    <= stby_nxt;
      rst_en_r  <= rst_en_nxt;
      ctl_r     <= ctl_nxt;
    end
  end

  assign so            = so_r;
  assign so_oe         = so_oe_r;
  assign fwd           = fwd_r;
  assign eng_ctl       = ctl_r;
  assign busy_flag     = busy_r;
  assign suspend_flags = susp_r;
  assign power_down    = pd_r;
  assign standby       = stby_r;

endmodule

// ==== testbench/flash_powerdown_id_suspend_checker.sv ====
// Purpose: port-level assertions for the flash command interpreter
// Assumes: one clock domain; nrst is the only reset seen at the ports
// Notes:   bound into every instance of the design
`timescale 1ns/100ps
module flash_powerdown_id_suspend_checker
  import flash_cmd_pkg::*;
(
  input wire logic                clock,
  input wire logic                nrst,
  input flash_cmd_pkg::pin_in_s   pins,
  input flash_cmd_pkg::eng_s      eng,
  input wire logic                so,
  input wire logic                so_oe,
  input flash_cmd_pkg::fwd_s      fwd,
  input flash_cmd_pkg::eng_ctl_s  eng_ctl,
  input wire logic                busy_flag,
  input wire logic [1:0]          suspend_flags,
  input wire logic                power_down,
  input wire logic                standby
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // sequences and assertions
  // ----------------------------------------------------------------
  sequence deselect_in_data;
    so_oe && $rose(pins.cs_n);
  endsequence
  sequence output_released;
    ##[1:6] !so_oe;
  endsequence

  a_oe_abort: assert property (deselect_in_data |-> output_released)
    else $error("output still driven after deselect");
  a_pd_standby: assert property (power_down |-> !standby)
    else $error("standby shown in power-down");
  a_pd_no_fwd: assert property (power_down |-> !fwd.valid)
    else $error("opcode forwarded in power-down");
  a_pd_quiet: assert property (power_down |-> !eng_ctl.suspend_req && !eng_ctl.resume_req)
    else $error("power-down not quiet");
  // id output in power-down only comes from the release opcode, so deselect must wake
  a_pd_id_wake: assert property (power_down && so_oe && $rose(pins.cs_n) |->
    ##[1:4] !power_down)
    else $error("release with id left power-down set");
  a_pd_entry_wait: assert property ($rose(power_down) |-> $past(pins.cs_n, 6) && !busy_flag)
    else $error("power-down entered too early");
  a_sus_accept: assert property (eng_ctl.suspend_req |->
    $past(busy_flag) && $past(suspend_flags) == 2'b00)
    else $error("suspend accepted out of state");
  a_sus_kind: assert property (eng_ctl.suspend_req |->
    suspend_flags == ((eng.kind == ENG_ERASE) ? 2'b10 : 2'b01))
    else $error("wrong suspend flag");
  a_res_accept: assert property (eng_ctl.resume_req |-> $past(suspend_flags) != 2'b00 &&
    !$past(busy_flag) && busy_flag && suspend_flags == 2'b00)
    else $error("resume accepted out of state");
  a_flag_clear: assert property ($past(suspend_flags) != 2'b00 && suspend_flags == 2'b00
    |-> eng_ctl.resume_req || eng_ctl.abort_req)
    else $error("suspend flag cleared without cause");
  a_busy_mirror: assert property (!eng_ctl.resume_req && !eng_ctl.abort_req
    |-> busy_flag == $past(eng.busy))
    else $error("busy flag does not follow engine");
  a_reset_state: assert property (eng_ctl.abort_req |->
    !power_down && suspend_flags == 2'b00 && !busy_flag)
    else $error("soft reset left state behind");
endmodule

bind flash_powerdown_id_suspend flash_powerdown_id_suspend_checker chk_u (
  .clock(clock), .nrst(nrst), .pins(pins), .eng(eng), .so(so), .so_oe(so_oe),
  .fwd(fwd), .eng_ctl(eng_ctl), .busy_flag(busy_flag), .suspend_flags(suspend_flags),
  .power_down(power_down), .standby(standby)
);

// ==== testbench/spi_host_model.sv ====
// Purpose: behavioural serial host for the flash command interpreter
// Assumes: mode 0, sclk low between frames, 80 ns link period
// Notes:   delays are multiples of the 8 ns clock, so edges land on falling clock edges
`timescale 1ns/100ps
module spi_host_model
(
  output flash_cmd_pkg::pin_in_s pins,
  input  wire logic              so,
  input  wire logic              so_oe
);
  import flash_cmd_pkg::*;
  logic oe_seen;

  initial
  begin
    pins    = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
    oe_seen = 1'b0;
  end

  // bits clocked while reading toggle si so that no stale level looks meaningful
  task automatic frame(input logic [47:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx);
    rx        = '0;
    oe_seen   = 1'b0;
    pins.cs_n = 1'b0;
    #40;
    for (int i = 0; i < ntx + nrx; i++)
    begin
      pins.si = (i < ntx) ? tx[ntx-1-i] : ~pins.si;
      #40;
      pins.sclk = 1'b1;
      if (i >= ntx)
        rx = {rx[126:0], so};
      oe_seen = oe_seen | (so_oe === 1'b1);
      #40;
      pins.sclk = 1'b0;
    end
    #40;
    pins.cs_n = 1'b1;
    pins.si   = ~pins.si;
  endtask
endmodule

// ==== testbench/flash_powerdown_id_suspend_test.sv ====
// Purpose: self-checking bench for the flash command interpreter
// Assumes: a stand-in engine answers suspend, resume and abort requests
// Notes:   delay parameters shortened; expectations use the values set here
`timescale 1ns/100ps
module flash_powerdown_id_suspend_test;
  import flash_cmd_pkg::*;
  typedef struct {
    logic [47:0]  tx;
    int           ntx;
    int           nrx;
    logic [127:0] exp;
  } row_s;
  // identity values are arbitrary
  localparam logic [7:0]   MK  = 8'hC3;
  localparam logic [7:0]   DV  = 8'h4E;
  localparam logic [7:0]   MT  = 8'h71;
  localparam logic [7:0]   CP  = 8'h2B;
  localparam logic [127:0] UID = 128'h13579BDF02468ACE_FDB97531ECA86420;
  logic         clock = 1'b0;
  logic         nrst  = 1'b0;
  pin_in_s      pins;
  eng_s         eng   = '{busy: 1'b0, kind: ENG_OTHER};
  logic         so, so_oe, busy_flag, power_down, standby;
  logic [1:0]   suspend_flags;
  fwd_s         fwd;
  eng_ctl_s     eng_ctl;
  int           miscompares = 0;
  int           cmp_count   = 0;
  int           fwd_cnt     = 0;
  int           n;
  logic [127:0] rx;
  row_s         rows[5];
  logic [7:0]   prog_ref[12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20,
                                 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
  logic [7:0]   erase_ref[9] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52,
                                 8'hD8, 8'hC7, 8'h60};

  always #4 clock = ~clock;

  flash_powerdown_id_suspend #(.T_DP_NS(40), .T_RES1_NS(2000), .T_RES2_NS(2000),
    .T_RST_NS(40), .MAKER_ID(MK), .DEV_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP),
    .UNIQUE_ID(UID)) dut_u (
    .clock(clock), .nrst(nrst), .pins(pins), .eng(eng), .so(so), .so_oe(so_oe),
    .fwd(fwd), .eng_ctl(eng_ctl), .busy_flag(busy_flag),
    .suspend_flags(suspend_flags), .power_down(power_down), .standby(standby));

  spi_host_model host_u (.pins(pins), .so(so), .so_oe(so_oe));

  // stand-in engine: stops on suspend or abort, runs again on resume
  always @(negedge clock)
  begin
    if (fwd.valid === 1'b1)
      fwd_cnt++;
    if (eng_ctl.suspend_req === 1'b1 || eng_ctl.abort_req === 1'b1)
      eng.busy = 1'b0;
    if (eng_ctl.resume_req === 1'b1)
      eng.busy = 1'b1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic send(input logic [7:0] op);
    host_u.frame({40'h0, op}, 8, 0, rx);
    wait_cyc(10);
  endtask

  task automatic wait_pd(input logic v);
    for (int i = 0; i < 40 && power_down !== v; i++)
      @(negedge clock);
    if (power_down !== v)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  initial
  begin
    #500000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    rows[0] = '{{16'h0, 8'hAB, 24'h0}, 32, 16, 128'({DV, DV})};
    rows[1] = '{{16'h0, 8'h90, 24'h0}, 32, 32, 128'({MK, DV, MK, DV})};
    rows[2] = '{{40'h0, 8'h9F}, 8, 32, 128'({MK, MT, CP, MK})};
    rows[3] = '{{8'h0, 8'h4B, 32'h0}, 40, 128, UID};
    rows[4] = '{{40'h0, 8'h9F}, 8, 5, 128'(MK[7:3])};
    wait_cyc(5);
    nrst = 1'b1;
    wait_cyc(6);
    check({power_down, standby, busy_flag, suspend_flags}, 5'b01000, "reset state");
    foreach (rows[i])
    begin
      host_u.frame(rows[i].tx, rows[i].ntx, rows[i].nrx, rx);
      check(rx, rows[i].exp, "id data");
      wait_cyc(6);
      check({so_oe, standby}, 2'b01, "deselect to standby");
      wait_cyc(300);
    end
    // one clock too many after the opcode
    host_u.frame({39'h0, 8'hB9, 1'b0}, 9, 0, rx);
    wait_cyc(30);
    check(power_down, 1'b0, "long entry frame");
    eng = '{busy: 1'b1, kind: ENG_PROGRAM};
    wait_cyc(2);
    send(8'hB9);
    wait_cyc(20);
    check(power_down, 1'b0, "entry while busy");
    host_u.frame({16'h0, 8'hAB, 24'h0}, 32, 16, rx);
    check(host_u.oe_seen, 1'b0, "release id while busy");
    host_u.frame({40'h0, 8'h9F}, 8, 24, rx);
    check(host_u.oe_seen, 1'b0, "ident while busy");
    wait_cyc(10);
    send(8'h75);
    check({suspend_flags, busy_flag}, 3'b010, "program suspend");
    n = fwd_cnt;
    foreach (prog_ref[i]) send(prog_ref[i]);
    check(fwd_cnt, n, "program suspend refusals");
    send(8'h66);
    send(8'h99);
    check(suspend_flags, 2'b00, "soft reset in suspend");
    eng = '{busy: 1'b1, kind: ENG_ERASE};
    wait_cyc(2);
    send(8'h75);
    check(suspend_flags, 2'b10, "erase suspend");
    n = fwd_cnt;
    foreach (erase_ref[i]) send(erase_ref[i]);
    send(8'h02);
    check({fwd_cnt, fwd.opcode}, {n + 1, 8'h02}, "erase suspend refusals");
    send(8'h7A);
    check({suspend_flags, busy_flag}, 3'b001, "resume");
    eng.busy = 1'b0;
    wait_cyc(2);
    send(8'h75);
    send(8'h7A);
    check({suspend_flags, busy_flag}, 3'b000, "idle suspend and resume");
    host_u.frame({40'h0, 8'hB9}, 8, 0, rx);
    wait_cyc(2);
    check(power_down, 1'b0, "entry delay");
    wait_pd(1'b1);
    n = fwd_cnt;
    // no identification read other than release with id is aimed at a sleeping device
    send(8'h02);
    check({power_down, fwd_cnt}, {1'b1, n}, "power-down ignores");
    send(8'hAB);
    check(power_down, 1'b0, "release");
    send(8'h02);
    check(fwd_cnt, n, "frame inside release delay");
    wait_cyc(300);
    send(8'h02);
    check(fwd_cnt, n + 1, "frame after release delay");
    send(8'hB9);
    wait_pd(1'b1);
    host_u.frame({16'h0, 8'hAB, 24'h0}, 32, 8, rx);
    wait_cyc(4);
    check({power_down, rx[7:0]}, {1'b0, DV}, "release with id");
    send(8'h02);
    check(fwd_cnt, n + 1, "frame inside id release delay");
    wait_cyc(300);
    send(8'hB9);
    wait_pd(1'b1);
    send(8'h66);
    send(8'h99);
    check(power_down, 1'b0, "soft reset in power-down");
    send(8'hB9);
    wait_pd(1'b1);
    nrst = 1'b0;
    wait_cyc(2);
    nrst = 1'b1;
    wait_cyc(6);
    check({power_down, standby}, 2'b01, "power-up state");
    print_verdict();
  end
endmodule
